// *** pkg/gp_timer_pkg.sv ***
// Operation
// - Reset: counters and loads hold 0xFFFF
// - Reset: prescale counters and registers zero
// - Config 0 wide timer, 1 clock
// - Config 4 splits into two halves
// - Wide load write fills both halves
// - Wide value read joins both counts
// - Wide mode uses low half mode only
// - Wide counter counts down, reloads after zero
// - One-shot stops and clears enable; periodic continues
// - Zero sets sticky timeout flag, masked copy
// - Zero pulses trigger when trigger enabled
// - Load write while running loads the count at once
// - Freeze bit holds count until released
// - Clock mode counts up from one
// - Slow pin clock divided to one-second tick
// - Count equal match rolls to zero
// - Match sets clock flag, clear bit clears
// - Clock enable bit overrides freeze bits
// - Split halves: 16-bit count, 8-bit prescaler
// - Split zero reloads count and prescaler
// - Prescale p gives p+1 clocks per step
// - Mode field: one-shot 1, periodic 2
package gp_timer_pkg;

  localparam int ADDR_W = 8;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef enum logic [1:0] {
    MODE_WIDE = 2'b00,
    MODE_CLOCK = 2'b01,
    MODE_SPLIT = 2'b11
  } width_mode_t;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFF_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_A_MODE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_B_MODE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_CTL = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_MASK = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_RAW = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_MASKED = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_CLEAR = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_A_LOAD = 8'h28;
  localparam logic [ADDR_W-1:0] OFF_B_LOAD = 8'h2c;
  localparam logic [ADDR_W-1:0] OFF_MATCH = 8'h30;
  localparam logic [ADDR_W-1:0] OFF_A_PRESCALE = 8'h38;
  localparam logic [ADDR_W-1:0] OFF_B_PRESCALE = 8'h3c;
  localparam logic [ADDR_W-1:0] OFF_A_VALUE = 8'h48;
  localparam logic [ADDR_W-1:0] OFF_B_VALUE = 8'h4c;

  // Configuration and mode encodings
  localparam logic [2:0] CFG_WIDE = 3'h0;
  localparam logic [2:0] CFG_CLOCK = 3'h1;
  localparam logic [2:0] CFG_SPLIT = 3'h4;
  localparam logic [1:0] HALF_ONESHOT = 2'h1;
  localparam logic [1:0] HALF_PERIODIC = 2'h2;

  // Control bits; the high half sits one stride above the low half
  localparam int CTL_A_EN = 0;
  localparam int CTL_A_STALL = 1;
  localparam int CTL_RTC_EN = 4;
  localparam int CTL_A_OTE = 5;
  localparam int HALF_STRIDE = 8;

  // Status bits
  localparam int ST_A_TO = 0;
  localparam int ST_RTC = 3;
  localparam logic [15:0] ST_USED = 16'h0109;

  // Reset values
  localparam logic [15:0] CNT_RST = 16'hffff;
  localparam logic [15:0] LOAD_RST = 16'hffff;
  localparam logic [7:0] PRESCALE_RST = 8'h00;
  localparam logic [31:0] MATCH_RST = 32'hffff_ffff;
  localparam logic [31:0] RTC_START = 32'h0000_0001;

  // Slow clock to one-second tick
  localparam int SLOW_CLK_HZ = 32768;
  localparam int TICK_HZ = 1;
  localparam int RTC_DIV_CNT = SLOW_CLK_HZ / TICK_HZ;

  function automatic width_mode_t cfg_mode(input logic [2:0] cfg);
    unique case (cfg)
      CFG_CLOCK: cfg_mode = MODE_CLOCK;
      CFG_SPLIT: cfg_mode = MODE_SPLIT;
      default: cfg_mode = MODE_WIDE;
    endcase
  endfunction : cfg_mode

endpackage : gp_timer_pkg

// *** core/slow_tick_divider.sv ***
module slow_tick_divider
  import gp_timer_pkg::*;
#(
  parameter int DIV = RTC_DIV_CNT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic slow_clock_pin,
  output logic tick
);

  if (DIV < 2) begin : g_bad_div
    $error("slow_tick_divider: DIV must be at least 2");
  end

  localparam int CW = $clog2(DIV);

  logic sync1;
  logic sync2;
  logic last;
  logic [CW-1:0] edges;
  logic [CW-1:0] next_edges;
  logic next_tick;

  // Divide rising edges of the synchronised pin down to one tick
  always_comb begin
    next_edges = edges;
    next_tick = 1'b0;
    if (sync2 && !last) begin
      if (edges == CW'(DIV - 1)) begin
        next_edges = '0;
        next_tick = 1'b1;
      end else begin
        next_edges = edges + CW'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      last <= 1'b0;
      edges <= '0;
      tick <= 1'b0;
    end else begin
      sync1 <= slow_clock_pin;
      sync2 <= sync1;
      last <= sync2;
      edges <= next_edges;
      tick <= next_tick;
    end
  end

endmodule : slow_tick_divider

// *** core/gp_timer_oneshot_periodic_rtc.sv ***
// Decided for this implementation: the placing of the registers and the address-and-strobe port.
module gp_timer_oneshot_periodic_rtc
  import gp_timer_pkg::*;
#(
  parameter int RTC_DIV = RTC_DIV_CNT
) (
  input wire logic clk,
  input wire logic sys_rst,
  input bus_req_t reg_req,
  output logic [31:0] rdata,
  input wire logic slow_clock_pin,
  output logic adc_trigger,
  output logic irq
);

  logic [2:0] cfg;
  logic [1:0] hmode [2];
  logic [15:0] ctl;
  logic [15:0] mask;
  logic [15:0] raw;
  logic [15:0] load [2];
  logic [15:0] cnt [2];
  logic [7:0] pr [2];
  logic [7:0] pre [2];
  logic [31:0] match;

  logic [2:0] next_cfg;
  logic [1:0] next_hmode [2];
  logic [15:0] next_ctl;
  logic [15:0] next_mask;
  logic [15:0] next_raw;
  logic [15:0] next_load [2];
  logic [15:0] next_cnt [2];
  logic [7:0] next_pr [2];
  logic [7:0] next_pre [2];
  logic [31:0] next_match;
  logic [31:0] next_rdata;
  logic next_trigger;
  logic next_irq;

  logic rtc_tick;
  logic [1:0] ev;
  logic rtc_ev;
  logic [15:0] set_bits;
  logic [31:0] wide;
  logic [31:0] next_wide;
  width_mode_t mode;
  logic wr_load_a;
  logic wr_load_b;
  logic enter_clock;
  logic any_stall;

  assign mode = cfg_mode(cfg);
  assign wide = {cnt[1], cnt[0]};
  assign any_stall = ctl[CTL_A_STALL] || ctl[CTL_A_STALL + HALF_STRIDE];

  slow_tick_divider #(
    .DIV(RTC_DIV)
  ) u_tick (
    .clk(clk),
    .sys_rst(sys_rst),
    .slow_clock_pin(slow_clock_pin),
    .tick(rtc_tick)
  );

  always_comb begin
    next_cfg = cfg;
    next_hmode = hmode;
    next_ctl = ctl;
    next_mask = mask;
    next_load = load;
    next_cnt = cnt;
    next_pr = pr;
    next_pre = pre;
    next_match = match;
    next_wide = wide;
    ev = 2'b00;
    rtc_ev = 1'b0;
    wr_load_a = 1'b0;
    wr_load_b = 1'b0;
    enter_clock = 1'b0;
    set_bits = '0;
    next_raw = raw;

    if (reg_req.wr) begin
      case (reg_req.addr)
        OFF_CFG: begin
          next_cfg = reg_req.wdata[2:0];
          enter_clock = cfg_mode(reg_req.wdata[2:0]) == MODE_CLOCK &&
                        mode != MODE_CLOCK;
        end
        OFF_A_MODE: next_hmode[0] = reg_req.wdata[1:0];
        OFF_B_MODE: next_hmode[1] = reg_req.wdata[1:0];
        OFF_CTL: next_ctl = reg_req.wdata[15:0];
        OFF_MASK: next_mask = reg_req.wdata[15:0] & ST_USED;
        OFF_A_LOAD: begin
          wr_load_a = 1'b1;
          next_load[0] = reg_req.wdata[15:0];
          if (mode != MODE_SPLIT) begin
            next_load[1] = reg_req.wdata[31:16];
          end
        end
        OFF_B_LOAD: begin
          wr_load_b = 1'b1;
          next_load[1] = reg_req.wdata[15:0];
        end
        OFF_MATCH: next_match = reg_req.wdata;
        OFF_A_PRESCALE: next_pr[0] = reg_req.wdata[7:0];
        OFF_B_PRESCALE: next_pr[1] = reg_req.wdata[7:0];
        default: ;
      endcase
    end

    unique case (mode)
      MODE_WIDE: begin
        // Only the low half's mode field and bits steer the joined counter
        if (ctl[CTL_A_EN] && !ctl[CTL_A_STALL]) begin
          if (wide == '0) begin
            next_wide = {load[1], load[0]};
            ev[0] = 1'b1;
            if (hmode[0] == HALF_ONESHOT) begin
              next_ctl[CTL_A_EN] = 1'b0;
            end
          end else begin
            next_wide = wide - 32'h1;
          end
        end
      end
      MODE_CLOCK: begin
        if (ctl[CTL_A_EN] && rtc_tick &&
            (ctl[CTL_RTC_EN] || !any_stall)) begin
          if (wide == match) begin
            next_wide = '0;
            rtc_ev = 1'b1;
          end else begin
            next_wide = wide + 32'h1;
          end
        end
      end
      MODE_SPLIT: begin
        for (int i = 0; i < 2; i++) begin
          if (ctl[CTL_A_EN + HALF_STRIDE * i] &&
              !ctl[CTL_A_STALL + HALF_STRIDE * i]) begin
            if (pre[i] != 8'h00) begin
              next_pre[i] = pre[i] - 8'h01;
            end else begin
              next_pre[i] = pr[i];
              if (cnt[i] == 16'h0000) begin
                next_cnt[i] = load[i];
                ev[i] = 1'b1;
                if (hmode[i] == HALF_ONESHOT) begin
                  next_ctl[CTL_A_EN + HALF_STRIDE * i] = 1'b0;
                end
              end else begin
                next_cnt[i] = cnt[i] - 16'h0001;
              end
            end
          end
        end
      end
      default: ;
    endcase

    if (mode != MODE_SPLIT) begin
      next_cnt[0] = next_wide[15:0];
      next_cnt[1] = next_wide[31:16];
    end
    // Software loads win over the counting step of the same cycle
    if (wr_load_a) begin
      next_cnt[0] = reg_req.wdata[15:0];
      if (mode != MODE_SPLIT) begin
        next_cnt[1] = reg_req.wdata[31:16];
      end
      if (mode == MODE_SPLIT) begin
        next_pre[0] = pr[0];
      end
    end
    if (wr_load_b) begin
      next_cnt[1] = reg_req.wdata[15:0];
      next_pre[1] = pr[1];
    end
    if (enter_clock) begin
      next_cnt[0] = RTC_START[15:0];
      next_cnt[1] = RTC_START[31:16];
    end

    set_bits[ST_A_TO] = ev[0];
    set_bits[ST_A_TO + HALF_STRIDE] = ev[1];
    set_bits[ST_RTC] = rtc_ev;
    if (reg_req.wr && reg_req.addr == OFF_CLEAR) begin
      next_raw = raw & ~reg_req.wdata[15:0];
    end
    // A new event in the clearing cycle survives
    next_raw = next_raw | set_bits;
    next_irq = |(next_raw & next_mask);
    next_trigger = (ev[0] && ctl[CTL_A_OTE]) ||
                   (ev[1] && ctl[CTL_A_OTE + HALF_STRIDE]);

    next_rdata = '0;
    if (reg_req.rd) begin
      case (reg_req.addr)
        OFF_CFG: next_rdata = {29'h0, cfg};
        OFF_A_MODE: next_rdata = {30'h0, hmode[0]};
        OFF_B_MODE: next_rdata = {30'h0, hmode[1]};
        OFF_CTL: next_rdata = {16'h0, ctl};
        OFF_MASK: next_rdata = {16'h0, mask};
        OFF_RAW: next_rdata = {16'h0, raw};
        OFF_MASKED: next_rdata = {16'h0, raw & mask};
        OFF_A_LOAD: next_rdata = mode == MODE_SPLIT ? {16'h0, load[0]} :
                                 {load[1], load[0]};
        OFF_B_LOAD: next_rdata = {16'h0, load[1]};
        OFF_MATCH: next_rdata = match;
        OFF_A_PRESCALE: next_rdata = {24'h0, pr[0]};
        OFF_B_PRESCALE: next_rdata = {24'h0, pr[1]};
        OFF_A_VALUE: next_rdata = mode == MODE_SPLIT ? {16'h0, cnt[0]} :
                                  wide;
        OFF_B_VALUE: next_rdata = {16'h0, cnt[1]};
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg <= CFG_WIDE;
      ctl <= '0;
      mask <= '0;
      raw <= '0;
      match <= MATCH_RST;
      rdata <= '0;
      adc_trigger <= 1'b0;
      irq <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        hmode[i] <= 2'h0;
        load[i] <= LOAD_RST;
        cnt[i] <= CNT_RST;
        pr[i] <= PRESCALE_RST;
        pre[i] <= PRESCALE_RST;
      end
    end else begin
      cfg <= next_cfg;
      ctl <= next_ctl;
      mask <= next_mask;
      raw <= next_raw;
      match <= next_match;
      rdata <= next_rdata;
      adc_trigger <= next_trigger;
      irq <= next_irq;
      for (int i = 0; i < 2; i++) begin
        hmode[i] <= next_hmode[i];
        load[i] <= next_load[i];
        cnt[i] <= next_cnt[i];
        pr[i] <= next_pr[i];
        pre[i] <= next_pre[i];
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic quiet_wr;
  assign quiet_wr = !reg_req.wr;

  a_reset_counts: assert property ($past(sys_rst) |->
    cnt[0] == CNT_RST && cnt[1] == CNT_RST &&
    load[0] == LOAD_RST && load[1] == LOAD_RST && ctl == '0)
    else $error("counters or loads wrong after reset");

  a_reset_prescale: assert property ($past(sys_rst) |->
    pre[0] == 8'h00 && pre[1] == 8'h00 && pr[0] == 8'h00 && pr[1] == 8'h00)
    else $error("prescale not zero after reset");

  a_enter_clock: assert property (
    reg_req.wr && reg_req.addr == OFF_CFG &&
    reg_req.wdata[2:0] == CFG_CLOCK && mode != MODE_CLOCK
    |=> mode == MODE_CLOCK && wide == RTC_START)
    else $error("clock mode entry did not load one");

  a_enter_split: assert property (
    reg_req.wr && reg_req.addr == OFF_CFG && reg_req.wdata[2:0] == CFG_SPLIT
    |=> mode == MODE_SPLIT)
    else $error("split mode not selected");

  a_wide_load: assert property (
    reg_req.wr && reg_req.addr == OFF_A_LOAD && mode != MODE_SPLIT
    |=> {load[1], load[0]} == $past(reg_req.wdata) &&
        wide == $past(reg_req.wdata))
    else $error("wide load not split across halves");

  a_wide_read: assert property (
    reg_req.rd && reg_req.addr == OFF_A_VALUE && mode != MODE_SPLIT
    |=> rdata == $past(wide) ##1 ($past(reg_req.rd) || rdata == '0))
    else $error("wide value read wrong");

  a_wide_count: assert property (
    mode == MODE_WIDE && ctl[CTL_A_EN] && !ctl[CTL_A_STALL] && quiet_wr
    |=> wide == ($past(wide) == '0 ? {$past(load[1]), $past(load[0])} :
                 $past(wide) - 32'h1))
    else $error("wide counter step wrong");

  a_oneshot_stop: assert property (
    mode == MODE_WIDE && ctl[CTL_A_EN] && !ctl[CTL_A_STALL] &&
    wide == '0 && hmode[0] == HALF_ONESHOT && quiet_wr
    |=> !ctl[CTL_A_EN] && raw[ST_A_TO])
    else $error("one-shot did not stop");

  a_trigger_pulse: assert property (
    ev[0] && ctl[CTL_A_OTE] |=> adc_trigger)
    else $error("trigger missing on time-out");

  a_stall_hold: assert property (
    mode == MODE_WIDE && ctl[CTL_A_STALL] && quiet_wr |=> $stable(wide))
    else $error("stalled counter moved");

  a_clock_roll: assert property (
    mode == MODE_CLOCK && ctl[CTL_A_EN] && ctl[CTL_RTC_EN] && rtc_tick &&
    wide == match && quiet_wr |=> wide == '0 && raw[ST_RTC])
    else $error("clock match did not roll over");

  a_prescale_step: assert property (
    mode == MODE_SPLIT && ctl[CTL_A_EN] && !ctl[CTL_A_STALL] &&
    pre[0] != 8'h00 && quiet_wr
    |=> $stable(cnt[0]) && pre[0] == $past(pre[0]) - 8'h01)
    else $error("prescaler step wrong");

  a_split_reload: assert property (
    mode == MODE_SPLIT && ctl[CTL_A_EN] && !ctl[CTL_A_STALL] &&
    pre[0] == 8'h00 && cnt[0] == 16'h0000 && quiet_wr
    |=> cnt[0] == $past(load[0]) && pre[0] == $past(pr[0]) &&
        raw[ST_A_TO])
    else $error("split half did not reload");

  a_clock_override: assert property (
    mode == MODE_CLOCK && ctl[CTL_A_EN] && ctl[CTL_RTC_EN] && any_stall &&
    rtc_tick && wide != match && quiet_wr |=> wide == $past(wide) + 32'h1)
    else $error("clock counter froze despite clock enable");

  a_raw_sticky: assert property (
    raw[ST_A_TO] && !(reg_req.wr && reg_req.addr == OFF_CLEAR)
    |=> raw[ST_A_TO])
    else $error("time-out flag dropped without clear");

  c_wide_timeout: cover property (mode == MODE_WIDE && ev[0]);
  c_clock_match: cover property (rtc_ev);
  c_split_high: cover property (mode == MODE_SPLIT && ev[1]);
  c_oneshot_stop: cover property (ev[0] && hmode[0] == HALF_ONESHOT);
  c_clock_override: cover property (mode == MODE_CLOCK && any_stall && rtc_ev);

endmodule : gp_timer_oneshot_periodic_rtc

// *** dv/gp_timer_oneshot_periodic_rtc_tb.sv ***
module gp_timer_oneshot_periodic_rtc_tb
  import gp_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // Short divider keeps the clock-mode run brief
  localparam int DIV = 4;

  logic clk;
  logic sys_rst;
  logic slow_clock_pin = 1'b0;
  logic slow_run;
  logic adc_trigger;
  logic irq;
  bus_req_t reg_req;
  logic [31:0] rdata;
  logic [31:0] seed;
  logic [31:0] rd_val;
  logic [31:0] v1;
  logic [31:0] l;
  logic [7:0] p;
  logic [7:0] ob;
  int num_errors;
  int checks;
  int cyc;
  int n;
  int k;
  int h;

  gp_timer_oneshot_periodic_rtc #(.RTC_DIV(DIV))
    i_gp_timer_oneshot_periodic_rtc (
    .clk(clk),
    .sys_rst(sys_rst),
    .reg_req(reg_req),
    .rdata(rdata),
    .slow_clock_pin(slow_clock_pin),
    .adc_trigger(adc_trigger),
    .irq(irq)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    lfsr = {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
  endfunction : lfsr

  function automatic logic [31:0] step_period(input logic [31:0] ld,
                                              input logic [7:0] ps);
    step_period = (ld + 32'h1) * ({24'h0, ps} + 32'h1);
  endfunction : step_period

  task automatic final_report;
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    reg_req.wr <= 1'b0;
  endtask : wr

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk);
    reg_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    reg_req.rd <= 1'b0;
    #1 rd_val = rdata;
  endtask : rd_reg

  task automatic rchk(input string what, input logic [7:0] a,
                      input logic [31:0] exp);
    rd_reg(a);
    check(what, exp, rd_val);
  endtask : rchk

  // Edges from one sampled trigger pulse to the next, bounded
  task automatic wait_trig(output int c);
    c = 0;
    do begin
      @(posedge clk);
      c++;
    end while (adc_trigger !== 1'b1 && c < 20000);
  endtask : wait_trig

  task automatic count_trig(input int c, output int t);
    t = 0;
    repeat (c) begin
      @(posedge clk);
      if (adc_trigger === 1'b1) t++;
    end
  endtask : count_trig

  // Free-running cycle count: timeout and slow pin pacing
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (slow_run && cyc[2:0] == 3'h0) begin
      slow_clock_pin <= ~slow_clock_pin;
    end
    if (cyc == 40000) begin
      num_errors++;
      final_report;
    end
  end

  initial begin
    reg_req = '0;
    slow_run = 1'b0;
    sys_rst = 1'b1;
    seed = 32'h5b90bb73;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rchk("value", OFF_A_VALUE, 32'hffffffff);
    rchk("b_load", OFF_B_LOAD, {16'h0, LOAD_RST});
    rchk("ctl", OFF_CTL, 32'h0);
    rchk("a_pre", OFF_A_PRESCALE, {24'h0, PRESCALE_RST});
    rchk("b_pre", OFF_B_PRESCALE, 32'h0);
    rchk("unmapped", 8'h80, 32'h0);
    seed = lfsr(seed);
    wr(OFF_A_LOAD, seed);
    rchk("b_load", OFF_B_LOAD, {16'h0, seed[31:16]});
    rchk("joined", OFF_A_VALUE, seed);
    l = {27'h0, seed[4:0]} + 32'h3;
    wr(OFF_A_MODE, {30'h0, HALF_PERIODIC});
    // High half mode set opposite; wide mode must not follow it
    wr(OFF_B_MODE, {30'h0, HALF_ONESHOT});
    wr(OFF_A_LOAD, l);
    wr(OFF_CTL, 32'h21);
    wait_trig(n);
    wait_trig(n);
    check("wide_period", l + 32'h1, 32'(n));
    l = l + 32'h4;
    wr(OFF_A_LOAD, l);
    wait_trig(n);
    wait_trig(n);
    check("reload_period", l + 32'h1, 32'(n));
    wr(OFF_CTL, 32'h23);
    // Stall lands three counts after the time-out seen
    rchk("freeze", OFF_A_VALUE, l - 32'h3);
    v1 = rd_val;
    repeat (6) @(posedge clk);
    rchk("freeze", OFF_A_VALUE, v1);
    wr(OFF_CTL, 32'h21);
    wait_trig(n);
    check("resume", 32'h1, {31'h0, n < 100});
    wr(OFF_CTL, 32'h0);
    rchk("raw", OFF_RAW, 32'h1);
    check("irq_off", 32'h0, {31'h0, irq});
    wr(OFF_MASK, 32'h1);
    rchk("masked", OFF_MASKED, 32'h1);
    check("irq_on", 32'h1, {31'h0, irq});
    wr(OFF_CLEAR, 32'h1);
    rchk("cleared", OFF_RAW, 32'h0);
    check("irq_clr", 32'h0, {31'h0, irq});
    wr(OFF_A_MODE, {30'h0, HALF_ONESHOT});
    wr(OFF_CTL, 32'h21);
    count_trig(4 * l + 20, k);
    check("oneshot", 32'h1, 32'(k));
    rchk("en_clr", OFF_CTL, 32'h20);
    wr(OFF_CTL, 32'h1);
    count_trig(2 * l + 20, k);
    check("no_trig", 32'h0, 32'(k));
    wr(OFF_CLEAR, 32'h109);
    wr(OFF_CFG, {29'h0, CFG_SPLIT});
    // Both halves, prescale corners 0xff and 0x00 among random ones
    for (int i = 0; i < 4; i++) begin
      h = i % 2;
      ob = (h == 1) ? 8'h04 : 8'h00;
      seed = lfsr(seed);
      l = {28'h0, seed[3:0]} + 32'h1;
      p = (i == 1) ? 8'hff : ((i == 2) ? 8'h00 : seed[15:8]);
      wr(OFF_A_MODE + ob, {30'h0, HALF_PERIODIC});
      wr(OFF_A_PRESCALE + ob, {24'h0, p});
      wr(OFF_A_LOAD + ob, l);
      wr(OFF_CTL, 32'h21 << (8 * h));
      wait_trig(n);
      wait_trig(n);
      check("split", step_period(l, p), 32'(n));
      wr(OFF_CTL, 32'h0);
      rchk("split_raw", OFF_RAW, 32'h1 << (8 * h));
      wr(OFF_CLEAR, 32'h101);
    end
    wr(OFF_CFG, {29'h0, CFG_CLOCK});
    rchk("rtc_start", OFF_A_VALUE, RTC_START);
    rchk("cfg", OFF_CFG, {29'h0, CFG_CLOCK});
    wr(OFF_MATCH, 32'h2);
    wr(OFF_MASK, 32'h1 << ST_RTC);
    slow_run <= 1'b1;
    // Both freeze bits set: clock enable must override them
    wr(OFF_CTL, 32'h213);
    n = 0;
    do begin
      rd_reg(OFF_RAW);
      n += 2;
    end while (rd_val[ST_RTC] !== 1'b1 && n < 400);
    check("rtc_raw", 32'h8, rd_val);
    check("tick_time", 32'h1, {31'h0, n >= 60 && n <= 150});
    rchk("rollover", OFF_A_VALUE, 32'h0);
    check("rtc_irq", 32'h1, {31'h0, irq});
    wr(OFF_CLEAR, 32'h1 << ST_RTC);
    rchk("rtc_clr", OFF_RAW, 32'h0);
    check("rtc_irq_clr", 32'h0, {31'h0, irq});
    slow_run <= 1'b0;
    final_report;
  end

endmodule : gp_timer_oneshot_periodic_rtc_tb
